// *** verilog/chain_addr.v ***
// Daisy-chain node addressing, role flags and port steering
//
// Operation
// R1: Host waits 100 us after direction change
// R2: Host gives every node a distinct address
// R3: Unprogrammed node answers at address zero
// R4: Base node may start at any address
// R5: Host assigns addresses sequentially along chain
// R6: Host activates all nodes before addressing
// R7: Unaddressed node accepts only broadcast writes
// R8: Learned address stored per direction select
// R9: Learn mode mutes forwarding for one frame
// R10: Host sets role flags per chain position
// R11: Broadcast and stack reads need role flags; broadcast reads here need only an address
// R12: Host dummy-writes eight sync registers after reset
// R13: Host starts by setting learn mode
// R14: Host broadcasts consecutive addresses, one per node
// R15: Host sets roles singly or broadcast-then-fix
// R16: Host dummy-reads sync registers, tolerates loss
// R17: Host should read back addresses
// R18: Sync may raise faults; host clears them
// R19: Written address takes effect immediately
// R20: Reset loads operating addresses from OTP
// R21: Shadows never serve as operating address
// R22: Host skips assignment only if programmed
// R23: Host does one-byte dummy after sleep exit
// R24: Chain end disables its upstream transmitter
// R25: Role base if woken by UART, else stack
`timescale 1ns/1ps
`include "chain_addr_regs.vh"
module chain_addr #(
	parameter SETTLE_CYCLES = (`SETTLE_NS + `CLK_NS - 1) / `CLK_NS
) (
	input  wire           ref_clk,
	input  wire           rst_n,
	input  wire [`AW-1:0] addr,
	input  wire [`DW-1:0] wdata,
	input  wire           wr,
	input  wire           rd,
	output reg  [`DW-1:0] rdata,
	input  wire           frame_start,
	input  wire           frame_bcast_wr,
	input  wire           frame_bcast_rd,
	input  wire           frame_stack,
	input  wire           frame_wr,
	input  wire [`AW-1:0] frame_reg,
	input  wire [`DW-1:0] frame_data,
	input  wire [`ID_W-1:0] frame_target,
	input  wire           frame_single,
	input  wire           frame_err,
	output wire           frame_accept,
	input  wire           otp_valid,
	input  wire [`ID_W-1:0] otp_addr0,
	input  wire [`ID_W-1:0] otp_addr1,
	input  wire           wake_uart_pin,
	input  wire           wake_tone_pin,
	input  wire           sleep_exit_signal,
	output wire [`ID_W-1:0] node_id_field,
	output wire           stack_member_flag,
	output wire           chain_end_node,
	output wire           is_base,
	output wire           upper_tx_en,
	output wire           lower_tx_en,
	output wire           upper_rx_en,
	output wire           lower_rx_en,
	output wire           port_settling,
	output wire           addressed
);
	reg             dir_reg;         // Direction select
	reg             learn_reg;       // Address-learn mode
	reg             member_reg;      // Stack-member flag
	reg             end_reg;         // Chain-end flag
	reg [`ID_W-1:0] addr0_reg;       // First-direction address
	reg [`ID_W-1:0] addr1_reg;       // Second-direction address
	reg [`ID_W-1:0] shad0_reg;       // First-direction OTP shadow
	reg [`ID_W-1:0] shad1_reg;       // Second-direction OTP shadow
	reg             addr_done_reg;   // Node has an address
	reg             mute_reg;        // Forwarding muted this frame
	reg             base_reg;        // Woken through UART
	reg             fault_reg;       // Sync fault, sticky
	reg             load_reg;        // OTP load pending after reset
	reg [`DW-1:0]   dsync_reg [0:`DSYNC_N]; // Dummy sync data
	wire            wake_uart;       // Synchronised wake ping
	wire            wake_tone;       // Synchronised wake tone
	wire            sleep_exit;      // Synchronised sleep exit
	reg             sleep_exit_d_reg; // Edge detect delay
	wire            dir_wr;          // Software or frame dir change
	wire            host_wr_ctrl;    // Host write to control register
	wire            f_ok;            // Frame passes filter
	wire            f_wr;            // Accepted frame write
	wire            learn_hit;       // Frame carries own address
	reg             dir_next;
	// True when an address falls into the dummy sync range
	function is_dsync;
		input [`AW-1:0] a;
		begin
			is_dsync = (a >= `OFS_DSYNC_LO) && (a <= `OFS_DSYNC_IN);
		end
	endfunction
	// Index into dummy sync array; range is checked by is_dsync
	function [3:0] dsync_idx;
		input [`AW-1:0] a;
		reg   [`AW-1:0] ofs;
		begin
			ofs       = a - `OFS_DSYNC_LO;
			dsync_idx = ofs[3:0];
		end
	endfunction
	// Pins from outside the domain
	sync2 u_sync_uart (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.d       (wake_uart_pin),
		.q       (wake_uart)
	);
	sync2 u_sync_tone (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.d       (wake_tone_pin),
		.q       (wake_tone)
	);
	sync2 u_sync_sleep (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.d       (sleep_exit_signal),
		.q       (sleep_exit)
	);
	// Operating address picked by direction, never the shadows
	assign node_id_field = dir_reg ? addr1_reg : addr0_reg; // [R19] [R21]
	// Until addressed only broadcast writes pass; errored frames drop
	assign f_ok = !frame_err && (frame_bcast_wr ||
		(addr_done_reg && (frame_bcast_rd ||
		(frame_single && frame_target == node_id_field) ||
		(frame_stack && member_reg))));                         // [R7] [R11]
	// Accept strobe only while a frame is present
	assign frame_accept = frame_start && f_ok;
	assign f_wr = frame_accept && frame_wr;
	// Learned address goes to the register of the active direction
	assign learn_hit = f_wr && learn_reg &&
		(frame_reg == (dir_reg ? `OFS_ADDR1 : `OFS_ADDR0));      // [R8] [R9]
	assign host_wr_ctrl = wr && (addr == `OFS_CTRL);
	// Next direction; a host write beats a frame write in one cycle
	always @* begin
		dir_next = dir_reg;
		if (f_wr && frame_reg == `OFS_CTRL)
			dir_next = frame_data[`BIT_DIR];
		if (host_wr_ctrl)
			dir_next = wdata[`BIT_DIR];
	end
	// Any change restarts the settle window; ports stay dark meanwhile
	assign dir_wr = (dir_next != dir_reg);
	// Ports are reconfigured after a direction change
	settle_timer #(
		.CYCLES (SETTLE_CYCLES),
		.W      (13)
	) u_settle (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.start   (dir_wr),
		.busy    (port_settling)
	);
	// Main register state
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dir_reg       <= 1'b0;
			learn_reg     <= 1'b0;
			member_reg    <= 1'b0;
			end_reg       <= 1'b0;
			addr0_reg     <= `ADDR_RESET;                     // [R3]
			addr1_reg     <= `ADDR_RESET;
			shad0_reg     <= `ADDR_RESET;
			shad1_reg     <= `ADDR_RESET;
			addr_done_reg <= 1'b0;
			mute_reg      <= 1'b0;
			base_reg      <= 1'b0;
			fault_reg     <= 1'b0;
			load_reg      <= 1'b1;
			sleep_exit_d_reg <= 1'b0;
		end else begin
			sleep_exit_d_reg <= sleep_exit;
			dir_reg <= dir_next;
			// First cycle after reset copies programmed OTP values
			if (load_reg) begin
				load_reg <= 1'b0;
				if (otp_valid) begin
					addr0_reg     <= otp_addr0;             // [R20]
					addr1_reg     <= otp_addr1;
					shad0_reg     <= otp_addr0;
					shad1_reg     <= otp_addr1;
					addr_done_reg <= 1'b1;
				end
			end
			// Wake source fixes the role; tone wins only without ping
			if (wake_uart)
				base_reg <= 1'b1;                           // [R25]
			else if (wake_tone)
				base_reg <= 1'b0;
			// Frame-side writes
			if (f_wr) begin
				case (frame_reg)
				`OFS_CTRL: begin
					learn_reg <= frame_data[`BIT_LEARN];
				end
				`OFS_ROLE: begin
					member_reg <= frame_data[`BIT_MEMBER];
					end_reg    <= frame_data[`BIT_END];
				end
				`OFS_ADDR0: begin
					if (!learn_reg || !dir_reg)
						addr0_reg <= frame_data[`ID_W-1:0]; // [R19]
				end
				`OFS_ADDR1: begin
					if (!learn_reg || dir_reg)
						addr1_reg <= frame_data[`ID_W-1:0];
				end
				default: begin
				end
				endcase
			end
			// One frame kept, learn mode leaves, forwarding muted
			if (learn_hit) begin
				learn_reg     <= 1'b0;                      // [R9]
				mute_reg      <= 1'b1;
				addr_done_reg <= 1'b1;
			end else if (frame_start) begin
				mute_reg <= 1'b0;                           // [R9]
			end
			// Host-side register writes
			if (wr) begin
				case (addr)
				`OFS_CTRL:  learn_reg  <= wdata[`BIT_LEARN];
				`OFS_ROLE: begin
					member_reg <= wdata[`BIT_MEMBER];
					end_reg    <= wdata[`BIT_END];
				end
				`OFS_ADDR0: addr0_reg <= wdata[`ID_W-1:0];
				`OFS_ADDR1: addr1_reg <= wdata[`ID_W-1:0];
				`OFS_SHAD0: shad0_reg <= wdata[`ID_W-1:0];   // [R21]
				`OFS_SHAD1: shad1_reg <= wdata[`ID_W-1:0];
				default: begin
				end
				endcase
			end
			// Sync faults are sticky; a new one beats the clear
			if (wr && addr == `OFS_FAULT && wdata[0])
				fault_reg <= 1'b0;
			if ((frame_start && frame_err) ||
				(sleep_exit && !sleep_exit_d_reg))
				fault_reg <= 1'b1;                          // [R18]
		end
	end
	// Dummy sync storage; written by frames or host, no other effect
	genvar gi;
	generate
		for (gi = 0; gi <= `DSYNC_N; gi = gi + 1) begin : g_dsync
			always @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n)
					dsync_reg[gi] <= 8'h00;
				else if (f_wr && is_dsync(frame_reg) &&
					dsync_idx(frame_reg) == gi)
					dsync_reg[gi] <= frame_data;
				else if (wr && is_dsync(addr) && dsync_idx(addr) == gi)
					dsync_reg[gi] <= wdata;
			end
		end
	endgenerate
	// Read data one cycle after the strobe; unmapped reads zero
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else if (rd) begin
			case (addr)
			`OFS_CTRL:   rdata <= {6'h00, learn_reg, dir_reg};
			`OFS_ROLE:   rdata <= {6'h00, end_reg, member_reg};
			`OFS_ADDR0:  rdata <= {2'h0, addr0_reg};
			`OFS_ADDR1:  rdata <= {2'h0, addr1_reg};
			`OFS_SHAD0:  rdata <= {2'h0, shad0_reg};
			`OFS_SHAD1:  rdata <= {2'h0, shad1_reg};
			`OFS_STATUS: rdata <= {4'h0, port_settling, mute_reg,
				base_reg, addr_done_reg};
			`OFS_FAULT:  rdata <= {7'h00, fault_reg};
			default:
				rdata <= is_dsync(addr) ? dsync_reg[dsync_idx(addr)]
					: 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end
	// Direction 0 forwards up, 1 forwards down; base uses one side
	assign upper_tx_en = !dir_reg && !mute_reg && !end_reg &&
		!port_settling;                                      // [R24] [R9]
	assign lower_tx_en = dir_reg && !mute_reg && !end_reg &&
		!port_settling;                                      // [R24]
	// Base listens only on the side it forwards to; stack uses both
	assign upper_rx_en = !port_settling && (!dir_reg || !base_reg); // [R25]
	assign lower_rx_en = !port_settling && (dir_reg || !base_reg);
	// Role and state flags straight from registers
	assign stack_member_flag = member_reg;
	assign chain_end_node    = end_reg;
	assign is_base           = base_reg;
	assign addressed         = addr_done_reg;
endmodule // chain_addr

// *** verilog/chain_addr_regs.vh ***
// Register map, field layout and timing constants of the chain addressing
`ifndef CHAIN_ADDR_REGS_VH
`define CHAIN_ADDR_REGS_VH
`define AW            8
`define DW            8
`define ID_W          6
`define OFS_CTRL      8'h00
`define OFS_ROLE      8'h01
`define OFS_ADDR0     8'h02
`define OFS_ADDR1     8'h03
`define OFS_SHAD0     8'h04
`define OFS_SHAD1     8'h05
`define OFS_STATUS    8'h06
`define OFS_FAULT     8'h07
`define OFS_DSYNC_LO  8'h10
`define OFS_DSYNC_HI  8'h17
`define OFS_DSYNC_IN  8'h18
`define BIT_DIR       0
`define BIT_LEARN     1
`define BIT_MEMBER    0
`define BIT_END       1
`define ADDR_RESET    6'h00
`define SETTLE_NS     100000
`define CLK_NS        25
`define DSYNC_N       8
`endif

// *** verilog/sync2.v ***
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module sync2 (
	input  wire ref_clk,
	input  wire rst_n,
	input  wire d,
	output wire q
);
	reg meta_reg;  // First stage, read only by second
	reg q_reg;     // Second stage
	// Plain two-stage shift, reset to zero
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= 1'b0;
			q_reg    <= 1'b0;
		end else begin
			meta_reg <= d;
			q_reg    <= meta_reg;
		end
	end
	assign q = q_reg;
endmodule // sync2

// *** verilog/settle_timer.v ***
// Countdown that holds busy after a direction change
`timescale 1ns/1ps
module settle_timer #(
	parameter CYCLES = 4000,
	parameter W      = 13
) (
	input  wire ref_clk,
	input  wire rst_n,
	input  wire start,
	output wire busy
);
	reg [W-1:0] cnt_reg;  // Cycles left
	// Reload on start, otherwise count down to zero
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= {W{1'b0}};
		end else if (start) begin
			cnt_reg <= CYCLES[W-1:0];
		end else if (cnt_reg != {W{1'b0}}) begin
			cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
		end
	end
	assign busy = (cnt_reg != {W{1'b0}});
endmodule // settle_timer

// *** verif/chain_addr_props.sv ***
// Concurrent checks on the chain addressing node ports
`timescale 1ns/1ps
`include "chain_addr_regs.vh"
module chain_addr_props #(
	parameter SETTLE_CYCLES = 8
) (
	input wire           ref_clk,
	input wire           rst_n,
	input wire [`AW-1:0] addr,
	input wire           wr,
	input wire           frame_start,
	input wire           frame_bcast_wr,
	input wire           frame_stack,
	input wire           frame_wr,
	input wire           frame_err,
	input wire           frame_accept,
	input wire           otp_valid,
	input wire [`ID_W-1:0] otp_addr0,
	input wire [`ID_W-1:0] node_id_field,
	input wire           stack_member_flag,
	input wire           addressed,
	input wire           upper_tx_en,
	input wire           lower_tx_en,
	input wire           port_settling
);
	reg [15:0] set_cnt_reg; // Length of the current settling run
	// Count settling cycles; a plain repeat cannot take a parameter
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			set_cnt_reg <= 16'h0000;
		else if (port_settling)
			set_cnt_reg <= set_cnt_reg + 16'h0001;
		else
			set_cnt_reg <= 16'h0000;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	chk_err_drop: assert property (
		frame_start && frame_err |-> !frame_accept)
		else $error("errored frame accepted");
	chk_bwr_pass: assert property (
		frame_start && frame_bcast_wr && frame_wr && !frame_err |-> frame_accept)
		else $error("broadcast write refused");
	chk_unaddr_gate: assert property (
		frame_start && !addressed && !frame_bcast_wr |-> !frame_accept)
		else $error("unaddressed node took non-broadcast frame");
	chk_stack_gate: assert property (
		frame_start && frame_stack && !stack_member_flag |-> !frame_accept)
		else $error("stack frame taken without member flag");
	chk_otp_load: assert property (
		!$past(rst_n) && otp_valid |=>
		node_id_field == $past(otp_addr0) && addressed)
		else $error("programmed address not loaded at reset");
	chk_otp_blank: assert property (
		!$past(rst_n) && !otp_valid |=>
		node_id_field == `ADDR_RESET && !addressed)
		else $error("blank node not at default address");
	chk_shadow_iso: assert property (
		wr && (addr == `OFS_SHAD0 || addr == `OFS_SHAD1) && !frame_start
		|=> $stable(node_id_field))
		else $error("shadow write moved operating address");
	chk_settle_len: assert property (
		$fell(port_settling) |-> set_cnt_reg == SETTLE_CYCLES)
		else $error("settling window has wrong length");
	chk_tx_quiet: assert property (
		port_settling |-> !upper_tx_en && !lower_tx_en)
		else $error("transmitter on while ports settle");
	cover property (frame_accept);
	cover property ($fell(port_settling));
	cover property (frame_start && !frame_accept);
endmodule // chain_addr_props

bind chain_addr chain_addr_props #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_props (
	.ref_clk, .rst_n, .addr, .wr, .frame_start, .frame_bcast_wr,
	.frame_stack, .frame_wr, .frame_err, .frame_accept, .otp_valid,
	.otp_addr0, .node_id_field, .stack_member_flag, .addressed,
	.upper_tx_en, .lower_tx_en, .port_settling);

// *** verif/frame_host_model.sv ***
// Upstream frame source standing in for the host side of the chain
`timescale 1ns/1ps
module frame_host_model (
	input  wire       ref_clk,
	input  wire       frame_accept,
	output reg        frame_start    = 1'b0,
	output reg        frame_bcast_wr = 1'b0,
	output reg        frame_bcast_rd = 1'b0,
	output reg        frame_stack    = 1'b0,
	output reg        frame_single   = 1'b0,
	output reg        frame_wr       = 1'b0,
	output reg  [7:0] frame_reg      = 8'h00,
	output reg  [7:0] frame_data     = 8'h00,
	output reg  [5:0] frame_target   = 6'h00,
	output reg        frame_err      = 1'b0
);
	reg acc = 1'b0; // Whether the node took the last frame
	// One frame: launched after an edge, held until the taking edge
	task send(input [3:0] k, input [7:0] r, input [7:0] d,
		input [5:0] t, input e);
	begin
		@(posedge ref_clk);
		{frame_bcast_wr, frame_bcast_rd, frame_stack, frame_single} <= k;
		frame_wr     <= !k[2];
		frame_reg    <= r;
		frame_data   <= d;
		frame_target <= t;
		frame_err    <= e;
		frame_start  <= 1'b1;
		@(posedge ref_clk);
		acc = frame_accept;
		frame_start <= 1'b0;
		// Stale register and data fields flip so they never pass for a fresh frame
		frame_reg   <= ~r;
		frame_data  <= ~d;
	end
	endtask
endmodule // frame_host_model

// *** verif/chain_addr_tb_top.sv ***
// Self-checking bench for the chain addressing node
`timescale 1ns/1ps
`include "chain_addr_regs.vh"
module chain_addr_tb_top;
	localparam SC = 8; // Short settling window
	localparam BW = 4'h8, BR = 4'h4, SK = 4'h2, SG = 4'h1; // Frame kinds
	reg        ref_clk = 1'b0, rst_n = 1'b0;
	reg  [7:0] addr = 8'h00, wdata = 8'h00;
	reg        wr = 1'b0, rd = 1'b0, otp_valid = 1'b0;
	reg  [5:0] otp_addr0 = 6'h00, otp_addr1 = 6'h00;
	reg        wake_uart_pin = 1'b0, wake_tone_pin = 1'b0;
	reg        sleep_exit_signal = 1'b0;
	wire [7:0] rdata, frame_reg, frame_data;
	wire [5:0] node_id_field, frame_target;
	wire       frame_start, frame_bcast_wr, frame_bcast_rd, frame_stack;
	wire       frame_single, frame_wr, frame_err, frame_accept;
	wire       stack_member_flag, chain_end_node, is_base, upper_tx_en;
	wire       lower_tx_en, port_settling, addressed;
	wire       upper_rx_en, lower_rx_en;
	integer    error_cnt = 0, checked = 0, cyc = 0, i;
	chain_addr #(.SETTLE_CYCLES(SC)) dut (.ref_clk, .rst_n, .addr, .wdata,
		.wr, .rd, .rdata, .frame_start, .frame_bcast_wr, .frame_bcast_rd,
		.frame_stack, .frame_wr, .frame_reg, .frame_data, .frame_target,
		.frame_single, .frame_err, .frame_accept, .otp_valid, .otp_addr0,
		.otp_addr1, .wake_uart_pin, .wake_tone_pin,
		.sleep_exit_signal, .node_id_field, .stack_member_flag,
		.chain_end_node, .is_base, .upper_tx_en, .lower_tx_en,
		.upper_rx_en, .lower_rx_en, .port_settling, .addressed);
	frame_host_model u_host (.ref_clk, .frame_accept, .frame_start,
		.frame_bcast_wr, .frame_bcast_rd, .frame_stack, .frame_single,
		.frame_wr, .frame_reg, .frame_data, .frame_target, .frame_err);
	// 40 MHz clock
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	// Hang guard: the sequence needs well under a thousand cycles
	always @(posedge ref_clk) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			error_cnt = error_cnt + 1;
			test_done;
		end
	end
	task test_done;
	begin
		if (error_cnt == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	task cmp(input [7:0] g, input [7:0] e);
	begin
		checked = checked + 1;
		if (g !== e) begin
			error_cnt = error_cnt + 1;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	end
	endtask
	// One-cycle bus write
	task wr_reg(input [7:0] a, input [7:0] d);
	begin
		@(posedge ref_clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	end
	endtask
	// Read; data stand only in the cycle after the strobe
	task rd_chk(input [7:0] a, input [7:0] e);
	begin
		@(posedge ref_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		cmp(rdata, e);
	end
	endtask
	// Frame through the upstream model, then check acceptance
	task fr(input [3:0] k, input [7:0] r, input [7:0] d, input [5:0] t,
		input e, input x);
	begin
		u_host.send(k, r, d, t, e);
		#1;
		cmp({7'h00, u_host.acc}, {7'h00, x});
	end
	endtask
	task rst_seq;
	begin
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
	end
	endtask
	// Main sequence: blank node, learn, roles, faults, reverse, OTP
	initial begin
		rst_seq;
		#1;
		cmp({2'h0, node_id_field}, 8'h00);
		rd_chk(`OFS_STATUS, 8'h00);
		fr(SG, `OFS_ROLE, 8'h03, 6'h00, 1'b0, 1'b0);
		fr(SK, `OFS_ROLE, 8'h01, 6'h00, 1'b0, 1'b0);
		fr(BR, `OFS_DSYNC_LO, 8'h00, 6'h00, 1'b0, 1'b0);
		for (i = 0; i < `DSYNC_N; i = i + 1)
			fr(BW, `OFS_DSYNC_LO + i, 8'h00, 6'h00, 1'b0, 1'b1);
		fr(BW, `OFS_CTRL, 8'h02, 6'h00, 1'b0, 1'b1);
		fr(BW, `OFS_ADDR0, 8'h05, 6'h00, 1'b0, 1'b1);
		cmp({2'h0, node_id_field}, 8'h05);
		cmp({6'h00, upper_tx_en, lower_tx_en}, 8'h00);
		rd_chk(`OFS_CTRL, 8'h00);
		cmp({7'h00, addressed}, 8'h01);
		fr(BW, `OFS_DSYNC_IN, 8'hA5, 6'h00, 1'b0, 1'b1);
		cmp({7'h00, upper_tx_en}, 8'h01);
		fr(BW, `OFS_ROLE, 8'h01, 6'h00, 1'b0, 1'b1);
		fr(SG, `OFS_ROLE, 8'h03, 6'h06, 1'b0, 1'b0);
		fr(SG, `OFS_ROLE, 8'h03, 6'h05, 1'b0, 1'b1);
		cmp({6'h00, chain_end_node, upper_tx_en}, 8'h02);
		for (i = 0; i < `DSYNC_N; i = i + 1)
			fr(BR, `OFS_DSYNC_LO + i, 8'h00, 6'h00, 1'b0, 1'b1);
		fr(BR, `OFS_ADDR0, 8'h00, 6'h00, 1'b0, 1'b1);
		fr(SK, `OFS_DSYNC_IN, 8'h00, 6'h00, 1'b0, 1'b1);
		wr_reg(`OFS_ROLE, 8'h00);
		fr(SK, `OFS_DSYNC_IN, 8'h00, 6'h00, 1'b0, 1'b0);
		wr_reg(`OFS_SHAD0, 8'h2A);
		rd_chk(`OFS_SHAD0, 8'h2A);
		cmp({2'h0, node_id_field}, 8'h05);
		fr(BW, `OFS_DSYNC_IN, 8'h00, 6'h00, 1'b1, 1'b0);
		rd_chk(`OFS_FAULT, 8'h01);
		wr_reg(`OFS_FAULT, 8'h01);
		rd_chk(`OFS_FAULT, 8'h00);
		wr_reg(`OFS_CTRL, 8'h01);
		repeat (SC + 2) @(posedge ref_clk);
		#1;
		cmp({7'h00, port_settling}, 8'h00);
		cmp({2'h0, node_id_field}, 8'h00);
		fr(BW, `OFS_CTRL, 8'h03, 6'h00, 1'b0, 1'b1);
		fr(BW, `OFS_ADDR1, 8'h09, 6'h00, 1'b0, 1'b1);
		cmp({2'h0, node_id_field}, 8'h09);
		rd_chk(`OFS_ADDR0, 8'h05);
		@(posedge ref_clk);
		otp_valid <= 1'b1;
		otp_addr0 <= 6'h11;
		otp_addr1 <= 6'h22;
		rst_seq;
		rd_chk(`OFS_ADDR0, 8'h11);
		rd_chk(`OFS_ADDR1, 8'h22);
		cmp({7'h00, addressed}, 8'h01);
		fr(BW, `OFS_DSYNC_LO, 8'h00, 6'h00, 1'b0, 1'b1);
		fr(BR, `OFS_DSYNC_LO, 8'h00, 6'h00, 1'b0, 1'b1);
		@(posedge ref_clk);
		wake_uart_pin <= 1'b1;
		repeat (4) @(posedge ref_clk);
		#1;
		cmp({7'h00, is_base}, 8'h01);
		cmp({6'h00, upper_rx_en, lower_rx_en}, 8'h02);
		@(posedge ref_clk);
		wake_uart_pin <= 1'b0;
		wake_tone_pin <= 1'b1;
		repeat (4) @(posedge ref_clk);
		#1;
		cmp({7'h00, is_base}, 8'h00);
		cmp({6'h00, upper_rx_en, lower_rx_en}, 8'h03);
		@(posedge ref_clk);
		sleep_exit_signal <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rd_chk(`OFS_FAULT, 8'h01);
		fr(BW, `OFS_DSYNC_IN, 8'h5A, 6'h00, 1'b0, 1'b1);
		fr(BR, `OFS_DSYNC_IN, 8'h00, 6'h00, 1'b0, 1'b1);
		rd_chk(`OFS_DSYNC_IN, 8'h5A);
		test_done;
	end
endmodule // chain_addr_tb_top
